// ### pkg/prog_pkg.sv
// Constants, opcodes and state types of the serial programming port
`default_nettype none
package prog_pkg;
   // Clock and documented minimum wait delays
   localparam int MCLK_PERIOD_NS = 100;
   localparam real FLASH_PAGE_WRITE_WAIT_MS = 4.5;
   localparam real EEPROM_BYTE_WRITE_WAIT_MS = 9.0;
   localparam real CHIP_ERASE_WAIT_MS = 9.0;
   localparam int FLASH_PAGE_WRITE_WAIT_CYC =
      int'($ceil(FLASH_PAGE_WRITE_WAIT_MS * 1.0e6 / real'(MCLK_PERIOD_NS)));
   localparam int EEPROM_BYTE_WRITE_WAIT_CYC =
      int'($ceil(EEPROM_BYTE_WRITE_WAIT_MS * 1.0e6 / real'(MCLK_PERIOD_NS)));
   localparam int CHIP_ERASE_WAIT_CYC =
      int'($ceil(CHIP_ERASE_WAIT_MS * 1.0e6 / real'(MCLK_PERIOD_NS)));
   localparam int BUSY_W = 20;

   // Array geometry: byte addresses
   localparam int FLASH_AW = 13;
   localparam int EE_AW = 9;
   localparam int PAGE_AW = 6;
   localparam int PAGE_NUM_W = 7;

   // Instruction bytes
   localparam logic [7:0] OP_PROG_ENABLE = 8'hAC;
   localparam logic [7:0] PROG_ENABLE_KEY = 8'h53;
   localparam logic [2:0] ERASE_KEY = 3'h4;
   localparam logic [7:0] OP_HALF_MASK = 8'hF7;
   localparam logic [7:0] OP_READ_FLASH = 8'h20;
   localparam logic [7:0] OP_LOAD_PAGE = 8'h40;
   localparam logic [7:0] OP_WRITE_PAGE = 8'h4C;
   localparam logic [7:0] OP_READ_EE = 8'hA0;
   localparam logic [7:0] OP_WRITE_EE = 8'hC0;
   localparam int HALF_BIT = 3;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] IDLE_REPLY = 8'h00;

   // Bit counts within a frame (bits already received)
   localparam logic [4:0] ECHO_CAPTURE_CNT = 5'h0F;
   localparam logic [4:0] HEADER_CNT = 5'h17;
   localparam logic [4:0] LAST_BIT_CNT = 5'h1F;
   localparam logic [4:0] ECHO_OUT_CNT = 5'h10;

   // Sweep limits
   localparam logic [12:0] ERASE_LAST = 13'h1FFF;
   localparam logic [12:0] EE_SWEEP_END = 13'h0200;
   localparam logic [12:0] COMMIT_LAST = 13'h0040;

   typedef enum logic [1:0] {SWEEP_IDLE, SWEEP_ERASE, SWEEP_COMMIT} sweep_t;
   typedef enum logic [1:0] {BUSY_NONE, BUSY_FLASH, BUSY_EE, BUSY_ERASE} busy_t;
   typedef enum logic [1:0] {RD_NONE, RD_FLASH, RD_EE} rd_t;
endpackage
`default_nettype wire

// ### pkg/store_if.sv
// Port bundle between the programming logic and one byte array
`timescale 1ns/10ps
`default_nettype none
interface store_if #(parameter int AW = 6);
   logic [AW-1:0] addr;
   logic [7:0] wdata;
   logic we;
   logic [7:0] rdata;
   modport user (output addr, output wdata, output we, input rdata);
   modport store (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

// ### rtl/byte_store.sv
// Single port byte array with registered read data
`timescale 1ns/10ps
`default_nettype none
module byte_store #(parameter int AW = 6) (
   // Clock
   input wire logic clk,
   // Array port
   store_if.store port
);
   logic [7:0] cells [2**AW];

   // Read before write in the cycle (old data on a write), read data appears one edge later
   always_ff @(posedge clk) begin
      if (port.we) begin
         cells[port.addr] <= port.wdata;
      end
      port.rdata <= cells[port.addr];
   end
endmodule
`default_nettype wire

// ### rtl/serial_prog_port.sv
// Serial in-system programming port for the Flash and EEPROM arrays
// Summary of operation
// R1: Program and erase frames are ignored until programming enable was accepted.
// R2: An EEPROM write erases and rewrites the byte in one timed cycle.
// R3: Chip erase sets every Flash and EEPROM byte to all ones.
// R4: Programmer keeps each clock phase longer than two or three CPU cycles.
// R5: Serial input is sampled on the rising serial clock edge.
// R6: Serial output changes on the falling serial clock edge.
// R7: Programmer pulses reset high two cycles if clock was not low at power-up.
// R8: Programmer waits 20 ms after power-up before programming enable.
// R9: Second enable byte is echoed while the third byte shifts in.
// R10: Programmer always sends four bytes; on bad echo it resets and retries.
// R11: Page loads carry five low word address bits and one data byte.
// R12: Programmer loads the low byte before the high byte of a word.
// R13: Write page instruction with seven high address bits commits the buffer.
// R14: Without polling the programmer waits 4.5 ms between pages.
// R15: Without polling the programmer waits 9.0 ms between EEPROM bytes.
// R16: During a write the programmer sends only polling reads.
// R17: A read returns the addressed content on the serial output.
// R18: Reads inside a page being written return all ones until done.
// R19: Reads of an EEPROM byte being written return all ones until done.
// R20: Programmer waits the full delay when writing all-ones data.
// R21: Programmer waits 4.5 ms after fuse write, 9.0 ms after erase.
// R22: Reset pin high ends programming and the device resumes normal operation.
// R23: Enable is first byte AC hex, second byte 53 hex.
// R24: First byte AC hex with second byte 100xxxxx is chip erase.
// R25: First byte 4C hex is write page, address in bytes two and three.
// R26: First byte A0 hex reads EEPROM, data returned in byte four.
// R27: Frames are four bytes, MSB first, reply during the fourth byte.
`timescale 1ns/10ps
`default_nettype none
module serial_prog_port #(
   parameter int FLASH_WAIT_CYC = prog_pkg::FLASH_PAGE_WRITE_WAIT_CYC,
   parameter int EE_WAIT_CYC = prog_pkg::EEPROM_BYTE_WRITE_WAIT_CYC,
   parameter int ERASE_WAIT_CYC = prog_pkg::CHIP_ERASE_WAIT_CYC
) (
   // System clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Programming pins
   input wire logic prog_reset_n,
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   // Status towards the rest of the device
   output logic prog_active,
   output logic prog_enabled,
   output logic write_busy
);
   // Link side state
   logic [31:0] sh, next_sh;
   logic [4:0] cnt, next_cnt;
   logic [7:0] echo, next_echo;
   logic [23:0] hdr, next_hdr;
   logic [31:0] frame, next_frame;
   logic hdr_tgl, next_hdr_tgl;
   logic frm_tgl, next_frm_tgl;
   logic next_miso;
   // System side state
   logic [2:0] pin_s, next_pin_s;
   logic [2:0] frm_s, next_frm_s;
   logic [2:0] hdr_s, next_hdr_s;
   logic next_prog_active, next_prog_enabled;
   prog_pkg::sweep_t state, next_state;
   prog_pkg::busy_t busy_what, next_busy_what;
   prog_pkg::rd_t rd_pend, next_rd_pend;
   logic [12:0] sweep, next_sweep;
   logic [prog_pkg::PAGE_NUM_W-1:0] page, next_page;
   logic [prog_pkg::BUSY_W-1:0] busy_cnt, next_busy_cnt;
   logic [12:0] busy_tag, next_busy_tag;
   logic [12:0] rd_tag, next_rd_tag;
   logic [7:0] reply, next_reply;
   logic frm_go, hdr_go;
   logic [7:0] b1, b2, b3, b4, h1, h2, h3;

   store_if #(.AW(prog_pkg::FLASH_AW)) flash_bus ();
   store_if #(.AW(prog_pkg::EE_AW)) ee_bus ();
   store_if #(.AW(prog_pkg::PAGE_AW)) buf_bus ();

   byte_store #(.AW(prog_pkg::FLASH_AW)) flash_mem (.clk(mclk), .port(flash_bus.store));
   byte_store #(.AW(prog_pkg::EE_AW)) ee_mem (.clk(mclk), .port(ee_bus.store));
   byte_store #(.AW(prog_pkg::PAGE_AW)) page_buf (.clk(mclk), .port(buf_bus.store));

   // Receive shifter: whole frame and header are held for the other domain, the echo byte for the output
   always_comb begin
      next_sh = {sh[30:0], mosi}; // [R5] [R27]
      next_cnt = cnt + 5'h01;
      next_echo = echo;
      next_hdr = hdr;
      next_frame = frame;
      next_hdr_tgl = hdr_tgl;
      next_frm_tgl = frm_tgl;
      if (cnt == prog_pkg::ECHO_CAPTURE_CNT) begin
         next_echo = next_sh[7:0]; // [R9]
      end
      if (cnt == prog_pkg::HEADER_CNT) begin
         next_hdr = next_sh[23:0];
         next_hdr_tgl = !hdr_tgl;
      end
      if (cnt == prog_pkg::LAST_BIT_CNT) begin
         next_frame = next_sh; // [R27]
         next_frm_tgl = !frm_tgl;
      end
   end

   // Link clock stands still between frames; a high reset pin clears it at once
   always_ff @(posedge sck or posedge prog_reset_n) begin
      if (prog_reset_n) begin
         sh <= 32'h0000_0000;
         cnt <= 5'h00;
         echo <= 8'h00;
         hdr <= 24'h00_0000;
         frame <= 32'h0000_0000;
         hdr_tgl <= 1'b0;
         frm_tgl <= 1'b0;
      end else begin
         sh <= next_sh;
         cnt <= next_cnt;
         echo <= next_echo;
         hdr <= next_hdr;
         frame <= next_frame;
         hdr_tgl <= next_hdr_tgl;
         frm_tgl <= next_frm_tgl;
      end
   end

   // Output bit for the next position: echo in byte three, reply in byte four
   always_comb begin
      case (cnt[4:3])
         2'h2: next_miso = echo[~cnt[2:0]]; // [R9]
         2'h3: next_miso = reply[~cnt[2:0]]; // [R17] [R27]
         default: next_miso = 1'b0;
      endcase
   end

   // Reply is read quasi-static; it settles a few system cycles after the header
   always_ff @(negedge sck or posedge prog_reset_n) begin
      if (prog_reset_n) begin
         miso <= 1'b0;
      end else begin
         miso <= next_miso; // [R6]
      end
   end

   assign b1 = frame[31:24];
   assign b2 = frame[23:16];
   assign b3 = frame[15:8];
   assign b4 = frame[7:0];
   assign h1 = hdr[23:16];
   assign h2 = hdr[15:8];
   assign h3 = hdr[7:0];
   // Events are dropped once the reset pin is seen high, so a link clear is no frame
   assign frm_go = (frm_s[1] ^ frm_s[2]) && prog_active && !pin_s[1];
   assign hdr_go = (hdr_s[1] ^ hdr_s[2]) && prog_active && !pin_s[1];

   // Control: mode, frame decode, sweeps, busy timer and read replies
   always_comb begin
      next_pin_s = {pin_s[1:0], prog_reset_n};
      next_frm_s = {frm_s[1:0], frm_tgl};
      next_hdr_s = {hdr_s[1:0], hdr_tgl};
      next_prog_active = prog_active;
      next_prog_enabled = prog_enabled;
      next_state = state;
      next_sweep = sweep;
      next_page = page;
      next_busy_what = busy_what;
      next_busy_cnt = busy_cnt;
      next_busy_tag = busy_tag;
      next_rd_pend = prog_pkg::RD_NONE;
      next_rd_tag = rd_tag;
      next_reply = reply;
      flash_bus.addr = {h2[3:0], h3, h1[prog_pkg::HALF_BIT]};
      flash_bus.wdata = prog_pkg::ERASED_BYTE;
      flash_bus.we = 1'b0;
      ee_bus.addr = {h2[0], h3};
      ee_bus.wdata = b4;
      ee_bus.we = 1'b0;
      buf_bus.addr = {b3[4:0], b1[prog_pkg::HALF_BIT]};
      buf_bus.wdata = b4;
      buf_bus.we = 1'b0;
      if (pin_s[1] == pin_s[2]) begin
         next_prog_active = !pin_s[2]; // [R22]
      end
      if (!prog_active) begin
         next_prog_enabled = 1'b0; // [R22]
      end
      // Timer of the self-timed write; reads of the busy page or byte, or any read during erase, are masked while it runs
      if (busy_cnt != {prog_pkg::BUSY_W{1'b0}}) begin
         next_busy_cnt = busy_cnt - {{(prog_pkg::BUSY_W-1){1'b0}}, 1'b1};
         if (busy_cnt == {{(prog_pkg::BUSY_W-1){1'b0}}, 1'b1}) begin
            next_busy_what = prog_pkg::BUSY_NONE;
         end
      end
      // Frame decode; writes are taken only when no sweep runs
      if (frm_go) begin
         if (b1 == prog_pkg::OP_PROG_ENABLE && b2 == prog_pkg::PROG_ENABLE_KEY) begin
            next_prog_enabled = 1'b1; // [R23]
         end else if (prog_enabled && state == prog_pkg::SWEEP_IDLE) begin // [R1]
            if (b1 == prog_pkg::OP_PROG_ENABLE && b2[7:5] == prog_pkg::ERASE_KEY) begin
               next_state = prog_pkg::SWEEP_ERASE; // [R24]
               next_sweep = 13'h0000;
               next_busy_what = prog_pkg::BUSY_ERASE;
               next_busy_cnt = prog_pkg::BUSY_W'(ERASE_WAIT_CYC);
            end else if ((b1 & prog_pkg::OP_HALF_MASK) == prog_pkg::OP_LOAD_PAGE) begin
               buf_bus.we = 1'b1; // [R11]
            end else if (b1 == prog_pkg::OP_WRITE_PAGE) begin
               next_state = prog_pkg::SWEEP_COMMIT; // [R13] [R25]
               next_sweep = 13'h0000;
               next_page = {b2[3:0], b3[7:5]};
               next_busy_what = prog_pkg::BUSY_FLASH;
               next_busy_cnt = prog_pkg::BUSY_W'(FLASH_WAIT_CYC);
            end else if (b1 == prog_pkg::OP_WRITE_EE) begin
               // Overwrite in place covers the erase of the old byte
               ee_bus.addr = {b2[0], b3}; // [R2]
               ee_bus.we = 1'b1;
               next_busy_what = prog_pkg::BUSY_EE;
               next_busy_tag = {4'h0, b2[0], b3};
               next_busy_cnt = prog_pkg::BUSY_W'(EE_WAIT_CYC);
            end
         end
      end
      // Header decode starts the array read in time for the fourth byte
      if (hdr_go) begin
         next_reply = prog_pkg::IDLE_REPLY;
         if (prog_enabled && (h1 & prog_pkg::OP_HALF_MASK) == prog_pkg::OP_READ_FLASH) begin
            next_rd_pend = prog_pkg::RD_FLASH; // [R17]
            next_rd_tag = {h2[3:0], h3, h1[prog_pkg::HALF_BIT]};
         end else if (prog_enabled && h1 == prog_pkg::OP_READ_EE) begin
            next_rd_pend = prog_pkg::RD_EE; // [R26]
            next_rd_tag = {4'h0, h2[0], h3};
         end
      end
      case (rd_pend)
         prog_pkg::RD_FLASH: begin
            if (busy_what == prog_pkg::BUSY_ERASE ||
                  (busy_what == prog_pkg::BUSY_FLASH && rd_tag[12:6] == page)) begin
               next_reply = prog_pkg::ERASED_BYTE; // [R18]
            end else begin
               next_reply = flash_bus.rdata; // [R17]
            end
         end
         prog_pkg::RD_EE: begin
            if (busy_what == prog_pkg::BUSY_ERASE ||
                  (busy_what == prog_pkg::BUSY_EE && rd_tag == busy_tag)) begin
               next_reply = prog_pkg::ERASED_BYTE; // [R19]
            end else begin
               next_reply = ee_bus.rdata; // [R26]
            end
         end
         default: ;
      endcase
      // Sweeps own the arrays; reads landing in them are masked during erase, but during commit only for the page being written
      case (state)
         prog_pkg::SWEEP_ERASE: begin
            flash_bus.addr = sweep; // [R3]
            flash_bus.we = 1'b1;
            ee_bus.addr = sweep[8:0];
            ee_bus.wdata = prog_pkg::ERASED_BYTE; // [R3]
            ee_bus.we = (sweep < prog_pkg::EE_SWEEP_END);
            next_sweep = sweep + 13'h0001;
            if (sweep == prog_pkg::ERASE_LAST) begin
               next_state = prog_pkg::SWEEP_IDLE;
            end
         end
         prog_pkg::SWEEP_COMMIT: begin
            // Buffer read runs one cycle ahead of the Flash write
            buf_bus.addr = sweep[5:0];
            flash_bus.addr = {page, 6'(sweep[5:0] - 6'h01)}; // [R13]
            flash_bus.wdata = buf_bus.rdata;
            flash_bus.we = (sweep != 13'h0000);
            next_sweep = sweep + 13'h0001;
            if (sweep == prog_pkg::COMMIT_LAST) begin
               next_state = prog_pkg::SWEEP_IDLE;
            end
         end
         default: ;
      endcase
   end

   // System side registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_s <= 3'h7;
         frm_s <= 3'h0;
         hdr_s <= 3'h0;
         prog_active <= 1'b0;
         prog_enabled <= 1'b0;
         state <= prog_pkg::SWEEP_IDLE;
         sweep <= 13'h0000;
         page <= 7'h00;
         busy_what <= prog_pkg::BUSY_NONE;
         busy_cnt <= 20'h0_0000;
         busy_tag <= 13'h0000;
         rd_pend <= prog_pkg::RD_NONE;
         rd_tag <= 13'h0000;
         reply <= 8'h00;
      end else begin
         pin_s <= next_pin_s;
         frm_s <= next_frm_s;
         hdr_s <= next_hdr_s;
         prog_active <= next_prog_active;
         prog_enabled <= next_prog_enabled;
         state <= next_state;
         sweep <= next_sweep;
         page <= next_page;
         busy_what <= next_busy_what;
         busy_cnt <= next_busy_cnt;
         busy_tag <= next_busy_tag;
         rd_pend <= next_rd_pend;
         rd_tag <= next_rd_tag;
         reply <= next_reply;
      end
   end

   // Output driven only in programming mode
   assign miso_oe = prog_active; // [R22]
   assign write_busy = (busy_what != prog_pkg::BUSY_NONE);

   // Checks on the system side
   sequence s_page_cmd;
      frm_go && prog_enabled && b1 == prog_pkg::OP_WRITE_PAGE && state == prog_pkg::SWEEP_IDLE;
   endsequence
   sequence s_commit_run;
      (state == prog_pkg::SWEEP_COMMIT) ##64 (sweep == prog_pkg::COMMIT_LAST)
         ##1 (state == prog_pkg::SWEEP_IDLE);
   endsequence
   property p_page_commit;
      @(posedge mclk) disable iff (rst) s_page_cmd |=> s_commit_run;
   endproperty
   a_page_commit: assert property (p_page_commit) else $error("page commit sweep wrong"); // [R13]

   property p_enable;
      @(posedge mclk) disable iff (rst)
         frm_go && b1 == prog_pkg::OP_PROG_ENABLE && b2 == prog_pkg::PROG_ENABLE_KEY
         |=> prog_enabled;
   endproperty
   a_enable: assert property (p_enable) else $error("enable frame not accepted"); // [R23]

   property p_locked;
      @(posedge mclk) disable iff (rst)
         frm_go && !prog_enabled && state == prog_pkg::SWEEP_IDLE
         |=> state == prog_pkg::SWEEP_IDLE && !$changed(busy_what);
   endproperty
   a_locked: assert property (p_locked) else $error("write acted before enable"); // [R1]

   property p_erase_start;
      @(posedge mclk) disable iff (rst)
         frm_go && prog_enabled && state == prog_pkg::SWEEP_IDLE &&
         b1 == prog_pkg::OP_PROG_ENABLE && b2[7:5] == prog_pkg::ERASE_KEY
         |=> state == prog_pkg::SWEEP_ERASE && busy_what == prog_pkg::BUSY_ERASE;
   endproperty
   a_erase_start: assert property (p_erase_start) else $error("chip erase not started"); // [R24]

   property p_erase_ones;
      @(posedge mclk) disable iff (rst)
         state == prog_pkg::SWEEP_ERASE |-> flash_bus.we && flash_bus.wdata == 8'hFF &&
         (!ee_bus.we || ee_bus.wdata == 8'hFF);
   endproperty
   a_erase_ones: assert property (p_erase_ones) else $error("erase wrote non-ones"); // [R3]

   property p_ee_write;
      @(posedge mclk) disable iff (rst)
         frm_go && prog_enabled && state == prog_pkg::SWEEP_IDLE && b1 == prog_pkg::OP_WRITE_EE
         |-> ee_bus.we && ee_bus.wdata == b4 ##1 busy_what == prog_pkg::BUSY_EE;
   endproperty
   a_ee_write: assert property (p_ee_write) else $error("EEPROM write not issued"); // [R2]

   property p_poll_ones;
      @(posedge mclk) disable iff (rst)
         rd_pend == prog_pkg::RD_EE && busy_what == prog_pkg::BUSY_EE && rd_tag == busy_tag
         |=> reply == 8'hFF;
   endproperty
   a_poll_ones: assert property (p_poll_ones) else $error("busy EEPROM read not ones"); // [R19]

   property p_leave;
      @(posedge mclk) disable iff (rst) $fell(prog_active) |=> !prog_enabled && !miso_oe;
   endproperty
   a_leave: assert property (p_leave) else $error("programming mode not left"); // [R22]

   // Checks on the link side
   property p_sample_rise;
      @(posedge sck) disable iff (prog_reset_n) 1'b1 |=> sh[0] == $past(mosi);
   endproperty
   a_sample_rise: assert property (p_sample_rise) else $error("input not sampled"); // [R5]

   property p_echo;
      @(negedge sck) disable iff (prog_reset_n) cnt == prog_pkg::ECHO_OUT_CNT |=> miso == echo[7];
   endproperty
   a_echo: assert property (p_echo) else $error("echo bit missing"); // [R9]
endmodule
`default_nettype wire

// ### verification/prog_master.sv
// Behavioural programmer that drives four byte frames on the serial link
`timescale 1ns/10ps
`default_nettype none
module prog_master (
   // Serial link
   output logic sck,
   output logic mosi,
   input wire logic miso
);
   logic lclk = 1'b0;
   // Free running 64 ns base clock, unrelated in phase to the system clock
   always #32 lclk = ~lclk;
   // Serial clock rests low from power-up, so no extra reset pulse is needed
   initial begin
      sck = 1'b0;
      mosi = 1'b0;
   end
   // One frame, MSB first; phases span whole base periods to exceed two CPU cycles
   task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
      int i;
      rx = 32'h0000_0000;
      for (i = 31; i >= 0; i--) begin
         mosi = tx[i];
         repeat (4) @(posedge lclk);
         sck = 1'b1;
         rx[i] = miso;
         // Long high phase leaves time for the read reply to settle
         repeat (12) @(posedge lclk);
         sck = 1'b0;
      end
      // Released data line shows the inverse, never a stale bit
      mosi = ~tx[0];
      repeat (8) @(posedge lclk);
   endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking testbench of the serial programming port
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic prog_reset_n;
   logic sck, mosi, miso, miso_oe, prog_active, prog_enabled, write_busy;
   logic [31:0] rx;
   int error_cnt = 0;
   int num_checks = 0;
   // 10 MHz system clock
   always #50 mclk = ~mclk;
   // Short write delays keep the run brief, yet outlast one poll frame; erase outlasts its sweep
   serial_prog_port #(
      .FLASH_WAIT_CYC(1000),
      .EE_WAIT_CYC(1000),
      .ERASE_WAIT_CYC(9000)
   ) serial_prog_port_i (
      .mclk(mclk),
      .rst(rst),
      .prog_reset_n(prog_reset_n),
      .sck(sck),
      .mosi(mosi),
      .miso(miso),
      .miso_oe(miso_oe),
      .prog_active(prog_active),
      .prog_enabled(prog_enabled),
      .write_busy(write_busy)
   );
   prog_master prog_master_i (
      .sck(sck),
      .mosi(mosi),
      .miso(miso)
   );
   task automatic complete_run();
      $display("Checks %0d, errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask
   // One frame, then room for the command to cross and act
   task automatic xfer(input logic [31:0] tx);
      prog_master_i.frame(tx, rx);
      repeat (8) @(negedge mclk);
   endtask
   // Bounded wait for the self-timed delay to end
   task automatic wait_idle();
      int n;
      n = 0;
      while (write_busy !== 1'b0 && n < 20000) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 20000) begin
         error_cnt++;
         complete_run();
      end
   endtask
   task automatic t_enter();
      chk_flag(prog_active, 1'b0);
      chk_flag(prog_enabled, 1'b0);
      chk_flag(miso_oe, 1'b0);
      prog_reset_n = 1'b0;
      // Settle time shortened from the power-up wait
      repeat (10) @(negedge mclk);
      chk_flag(prog_active, 1'b1);
      chk_flag(miso_oe, 1'b1);
   endtask
   // Erase and write before enable must do nothing
   task automatic t_locked();
      xfer(32'hAC80_0000);
      chk_flag(write_busy, 1'b0);
      xfer(32'hC001_FF5A);
      chk_flag(write_busy, 1'b0);
      chk_flag(prog_enabled, 1'b0);
   endtask
   task automatic t_enable();
      xfer(32'hAC53_0000);
      chk_byte(rx[15:8], 8'h53);
      chk_flag(prog_enabled, 1'b1);
   endtask
   // Top EEPROM address, written twice without erase
   task automatic t_eeprom();
      xfer(32'hC001_FF5A);
      chk_flag(write_busy, 1'b1);
      xfer(32'hA001_FF00);
      chk_byte(rx[7:0], 8'hFF);
      wait_idle();
      xfer(32'hA001_FF00);
      chk_byte(rx[7:0], 8'h5A);
      xfer(32'hC001_FFA5);
      wait_idle();
      xfer(32'hA001_FF00);
      chk_byte(rx[7:0], 8'hA5);
   endtask
   // Word 0x023 lies in page 1, loaded low byte first
   task automatic t_flash();
      xfer(32'h4000_0311);
      xfer(32'h4800_0322);
      xfer(32'h4C00_2000);
      chk_flag(write_busy, 1'b1);
      xfer(32'h2000_2300);
      chk_byte(rx[7:0], 8'hFF);
      wait_idle();
      xfer(32'h2000_2300);
      chk_byte(rx[7:0], 8'h11);
      xfer(32'h2800_2300);
      chk_byte(rx[7:0], 8'h22);
   endtask
   task automatic t_erase();
      xfer(32'hAC9F_0000);
      chk_flag(write_busy, 1'b1);
      wait_idle();
      xfer(32'hA001_FF00);
      chk_byte(rx[7:0], 8'hFF);
      xfer(32'h2800_2300);
      chk_byte(rx[7:0], 8'hFF);
   endtask
   // Releasing the reset pin ends the session
   task automatic t_exit();
      prog_reset_n = 1'b1;
      repeat (10) @(negedge mclk);
      chk_flag(prog_active, 1'b0);
      chk_flag(prog_enabled, 1'b0);
      chk_flag(miso_oe, 1'b0);
   endtask
   // Main sequence, inputs changed at falling clock edges
   initial begin
      // A rising reset pin is the only clear of the link logic, so give it one
      @(negedge mclk);
      prog_reset_n = 1'b1;
      repeat (4) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      t_enter();
      t_locked();
      t_enable();
      t_eeprom();
      t_flash();
      t_erase();
      t_exit();
      complete_run();
   end
endmodule
`default_nettype wire
